// ### rtl/ccr_top.sv
/*
 Register file and control logic of an on-chip voltage comparator.
 Holds the latched compare result, enable, reference choice, thresholds,
 speed and mode, hysteresis, pin and bias settings and the interrupt mask,
 and drives them to the analog core.
 Assumes a register master that strobes one access per cycle, reads data
 one cycle after the read strobe, and a core decision synchronous to the
 clock.

*/
`timescale 1ns/100ps
`include "ccr_consts.svh"
module ccr_top (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Register port
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Analog core decision and sample task
	input  wire logic        decision_i,
	input  wire logic        sample_i,
	// Core control
	output logic             comp_active_o,
	output logic       [2:0] reference_choice_o,
	output logic             ref_valid_o,
	output logic             ref_applies_o,
	output logic       [2:0] external_ref_input_choice_o,
	output logic             external_ref_option_o,
	output logic       [5:0] lower_threshold_code_o,
	output logic       [5:0] upper_threshold_code_o,
	output logic       [1:0] speed_power_setting_o,
	output logic             diff_mode_o,
	output logic             hyst_en_o,
	output logic       [2:0] input_pin_choice_o,
	output logic       [1:0] input_bias_current_o,
	// Result and events
	output logic             result_o,
	output logic             ready_o,
	output logic             up_o,
	output logic             down_o,
	output logic             cross_o,
	output logic       [3:0] interrupt_enable_o
);

	// Register storage
	logic [1:0]  comparator_enable;
	logic [2:0]  reference_source;
	logic [2:0]  external_reference_input;
	logic [5:0]  lower_code;
	logic [5:0]  upper_code;
	logic [1:0]  speed_code;
	logic        main_mode;
	logic        hysteresis_control;
	logic [2:0]  input_pin_choice;
	logic [1:0]  input_bias_current;
	logic        active_q;

	// Decoded strobes
	logic        wr_enable;
	logic        wr_pinsel;
	logic        wr_refsrc;
	logic        wr_extref;
	logic        wr_thresh;
	logic        wr_opcfg;
	logic        wr_hyst;
	logic        wr_bias;
	logic        wr_inten;
	logic        wr_int_set;
	logic        wr_int_clr;

	// Internal status
	logic        active;
	logic        result;
	logic [3:0]  inten;
	logic [31:0] next_rdata;

	// Address match for one register word
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	// Reference codes that name a real source
	function automatic logic ref_known(input logic [2:0] code);
		case (code)
			ccr_pkg::CCR_REF_INT_LOW,
			ccr_pkg::CCR_REF_INT_MID,
			ccr_pkg::CCR_REF_INT_HIGH,
			ccr_pkg::CCR_REF_SUPPLY,
			ccr_pkg::CCR_REF_EXTERNAL: ref_known = 1'b1;
			default:                   ref_known = 1'b0;
		endcase
	endfunction

	// Write decode
	assign wr_enable   = wr_i & hit(addr_i, `CCR_OFF_ENABLE);
	assign wr_pinsel   = wr_i & hit(addr_i, `CCR_OFF_PINSEL);
	assign wr_refsrc   = wr_i & hit(addr_i, `CCR_OFF_REFSRC);
	assign wr_extref   = wr_i & hit(addr_i, `CCR_OFF_EXTREF);
	assign wr_thresh   = wr_i & hit(addr_i, `CCR_OFF_THRESH);
	assign wr_opcfg    = wr_i & hit(addr_i, `CCR_OFF_OPCFG);
	assign wr_hyst     = wr_i & hit(addr_i, `CCR_OFF_HYSTCTL);
	assign wr_bias     = wr_i & hit(addr_i, `CCR_OFF_BIAS);
	assign wr_inten    = wr_i & hit(addr_i, `CCR_OFF_INTEN);
	assign wr_int_set  = wr_i & hit(addr_i, `CCR_OFF_INT_SET);
	assign wr_int_clr  = wr_i & hit(addr_i, `CCR_OFF_INT_CLR);

	// Enable field; only the exact code 2 counts as on
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			comparator_enable <= `CCR_RST_ENABLE;
		else if (wr_enable)
			comparator_enable <= wdata_i[1:0];
	end

	assign active = (comparator_enable == `CCR_ENABLE_ON);

	// Reference source; reserved codes are stored but flagged invalid
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			reference_source <= `CCR_RST_REFSRC;
		else if (wr_refsrc)
			reference_source <= wdata_i[2:0];
	end

	// External reference input index
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			external_reference_input <= `CCR_RST_EXTREF;
		else if (wr_extref)
			external_reference_input <= wdata_i[2:0];
	end

	// Hysteresis threshold codes, both six bits wide
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			lower_code <= `CCR_RST_TH_CODE;
			upper_code <= `CCR_RST_TH_CODE;
		end
		else if (wr_thresh)
		begin
			lower_code <= wdata_i[`CCR_TH_LOW_LSB +: 6];
			upper_code <= wdata_i[`CCR_TH_HIGH_LSB +: 6];
		end
	end

	// Speed and power plus main mode
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			speed_code <= `CCR_RST_SPEED;
			main_mode  <= ccr_pkg::CCR_MAIN_SINGLE;
		end
		else if (wr_opcfg)
		begin
			speed_code <= wdata_i[1:0];
			main_mode  <= wdata_i[`CCR_OPCFG_MAIN_BIT];
		end
	end

	// Hysteresis on or off
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			hysteresis_control <= 1'b0;
		else if (wr_hyst)
			hysteresis_control <= wdata_i[0];
	end

	// Input pin choice, layout kept minimal
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			input_pin_choice <= `CCR_RST_PINSEL;
		else if (wr_pinsel)
			input_pin_choice <= wdata_i[2:0];
	end

	// Input bias current choice
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			input_bias_current <= `CCR_RST_BIAS;
		else if (wr_bias)
			input_bias_current <= wdata_i[1:0];
	end

	// Ready pulse one cycle after the comparator turns on
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			active_q <= 1'b0;
			ready_o  <= 1'b0;
		end
		else
		begin
			active_q <= active;
			ready_o  <= active & ~active_q;
		end
	end

	// Result latch and change events
	ccr_capture u_capture (
		.ref_clk_i  (ref_clk_i),
		.rst_b_i    (rst_b_i),
		.active_i   (active),
		.sample_i   (sample_i),
		.decision_i (decision_i),
		.result_o   (result),
		.up_o       (up_o),
		.down_o     (down_o),
		.cross_o    (cross_o)
	);

	// Interrupt enable mask
	ccr_inten u_inten (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.wr_all_i  (wr_inten),
		.wr_set_i  (wr_int_set),
		.wr_clr_i  (wr_int_clr),
		.wdata_i   (wdata_i[3:0]),
		.inten_o   (inten)
	);

	// Read mux; unmapped and unaligned addresses read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		case (addr_i)
			`CCR_OFF_INTEN,
			`CCR_OFF_INT_SET,
			`CCR_OFF_INT_CLR:
				next_rdata[3:0] = inten;
			`CCR_OFF_RESULT:
				next_rdata[0] = result;
			`CCR_OFF_ENABLE:
				next_rdata[1:0] = comparator_enable;
			`CCR_OFF_PINSEL:
				next_rdata[2:0] = input_pin_choice;
			`CCR_OFF_REFSRC:
				next_rdata[2:0] = reference_source;
			`CCR_OFF_EXTREF:
				next_rdata[2:0] = external_reference_input;
			`CCR_OFF_THRESH:
			begin
				next_rdata[`CCR_TH_LOW_LSB +: 6]  = lower_code;
				next_rdata[`CCR_TH_HIGH_LSB +: 6] = upper_code;
			end
			`CCR_OFF_OPCFG:
			begin
				next_rdata[1:0]                 = speed_code;
				next_rdata[`CCR_OPCFG_MAIN_BIT] = main_mode;
			end
			`CCR_OFF_HYSTCTL:
				next_rdata[0] = hysteresis_control;
			`CCR_OFF_BIAS:
				next_rdata[1:0] = input_bias_current;
			default:
				next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			rdata_o <= 32'h0000_0000;
		else if (rd_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= 32'h0000_0000;
	end

	// Core controls; reference only matters in single-ended mode
	assign comp_active_o               = active;
	assign reference_choice_o          = reference_source;
	assign ref_valid_o                 = ref_known(reference_source);
	assign ref_applies_o               = (main_mode == ccr_pkg::CCR_MAIN_SINGLE);
	assign diff_mode_o                 = (main_mode == ccr_pkg::CCR_MAIN_DIFF);
	assign external_ref_option_o       = ref_applies_o &
	                                     (reference_source == ccr_pkg::CCR_REF_EXTERNAL);
	assign external_ref_input_choice_o = external_reference_input;
	assign lower_threshold_code_o      = lower_code;
	assign upper_threshold_code_o      = upper_code;
	assign speed_power_setting_o       = speed_code;
	assign hyst_en_o                   = hysteresis_control;
	assign input_pin_choice_o          = input_pin_choice;
	assign input_bias_current_o        = input_bias_current;
	assign result_o                    = result;
	assign interrupt_enable_o          = inten;

endmodule // ccr_top

// ### rtl/ccr_consts.svh
/*
 Register offsets, field positions, reset values and small constants of the
 comparator control block. Assumes a 12-bit byte address on the register port.
*/
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// Byte offsets of the registers
`define CCR_OFF_INTEN        12'h300
`define CCR_OFF_INT_SET      12'h304
`define CCR_OFF_INT_CLR      12'h308
`define CCR_OFF_RESULT       12'h400
`define CCR_OFF_ENABLE       12'h500
`define CCR_OFF_PINSEL       12'h504
`define CCR_OFF_REFSRC       12'h508
`define CCR_OFF_EXTREF       12'h50c
`define CCR_OFF_THRESH       12'h530
`define CCR_OFF_OPCFG        12'h534
`define CCR_OFF_HYSTCTL      12'h538
`define CCR_OFF_BIAS         12'h53c

// Field positions
`define CCR_TH_LOW_LSB       0
`define CCR_TH_HIGH_LSB      8
`define CCR_OPCFG_MAIN_BIT   8

// Reset values
`define CCR_RST_ENABLE       2'h0
`define CCR_RST_REFSRC       3'h4
`define CCR_RST_EXTREF       3'h0
`define CCR_RST_TH_CODE      6'h00
`define CCR_RST_SPEED        2'h0
`define CCR_RST_PINSEL       3'h0
`define CCR_RST_BIAS         2'h0
`define CCR_RST_INTEN        4'h0

// Enable field code that turns the comparator on
`define CCR_ENABLE_ON        2'h2

`endif

// ### rtl/ccr_pkg.sv
/*
 Types of the comparator control block: reference codes, speed and power
 settings and main operation modes. Assumes nothing of its surroundings.
*/
package ccr_pkg;

	// Reference source codes
	typedef enum logic [2:0] {
		CCR_REF_INT_LOW  = 3'h0,
		CCR_REF_INT_MID  = 3'h1,
		CCR_REF_INT_HIGH = 3'h2,
		CCR_REF_SUPPLY   = 3'h4,
		CCR_REF_EXTERNAL = 3'h5
	} ccr_ref_t;

	// Speed and power settings
	typedef enum logic [1:0] {
		CCR_SPEED_LOW    = 2'h0,
		CCR_SPEED_NORMAL = 2'h1,
		CCR_SPEED_HIGH   = 2'h2
	} ccr_speed_t;

	// Main operation modes
	typedef enum logic {
		CCR_MAIN_SINGLE = 1'b0,
		CCR_MAIN_DIFF   = 1'b1
	} ccr_main_t;

endpackage

// ### rtl/ccr_capture.sv
/*
 Result latch of the comparator: takes the analog decision on a sample pulse
 while enabled and flags rising, falling and any change of the latched result.
 Assumes the core's decision is already synchronous to the clock.
*/
`timescale 1ns/100ps
module ccr_capture (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_b_i,
	// Core side
	input  wire logic active_i,
	input  wire logic sample_i,
	input  wire logic decision_i,
	// Latched result and events
	output logic      result_o,
	output logic      up_o,
	output logic      down_o,
	output logic      cross_o
);

	logic take;

	// A sample while disabled has no valid decision behind it
	assign take = sample_i & active_i;

	// Result holds until the next accepted sample
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			result_o <= 1'b0;
		else if (take)
			result_o <= decision_i;
	end

	// Event pulses, one cycle, only when the latched value changes
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			up_o    <= 1'b0;
			down_o  <= 1'b0;
			cross_o <= 1'b0;
		end
		else
		begin
			up_o    <= take & decision_i & ~result_o;
			down_o  <= take & ~decision_i & result_o;
			cross_o <= take & (decision_i ^ result_o);
		end
	end

endmodule // ccr_capture

// ### rtl/ccr_inten.sv
/*
 Interrupt enable mask with direct, write-one-to-set and write-one-to-clear
 access. Assumes the register port never strobes two of its writes at once.
*/
`timescale 1ns/100ps
`include "ccr_consts.svh"
module ccr_inten (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_b_i,
	// Write strobes
	input  wire logic       wr_all_i,
	input  wire logic       wr_set_i,
	input  wire logic       wr_clr_i,
	input  wire logic [3:0] wdata_i,
	// Mask
	output logic      [3:0] inten_o
);

	// Set and clear act only on bits written as one
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			inten_o <= `CCR_RST_INTEN;
		else if (wr_all_i)
			inten_o <= wdata_i;
		else if (wr_set_i)
			inten_o <= inten_o | wdata_i;
		else if (wr_clr_i)
			inten_o <= inten_o & ~wdata_i;
	end

endmodule // ccr_inten

// ### verification/ccr_top_assertions.sv
/*
 Concurrent checks on the ports of the comparator control block.
 Assumes a bind into ccr_top, one clock domain and an active-low reset.
*/
`timescale 1ns/100ps
`include "ccr_consts.svh"
module ccr_checker (
	// Clock, reset and register port
	input wire logic        ref_clk_i,
	input wire logic        rst_b_i,
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Core side
	input wire logic        decision_i,
	input wire logic        sample_i,
	input wire logic        comp_active_o,
	input wire logic [2:0]  reference_choice_o,
	input wire logic        diff_mode_o,
	input wire logic [2:0]  external_ref_input_choice_o,
	input wire logic        external_ref_option_o,
	input wire logic [5:0]  lower_threshold_code_o,
	input wire logic [5:0]  upper_threshold_code_o,
	input wire logic [1:0]  speed_power_setting_o,
	input wire logic        hyst_en_o,
	input wire logic        result_o,
	input wire logic        up_o,
	input wire logic        down_o,
	input wire logic        cross_o,
	input wire logic [3:0]  interrupt_enable_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// Accepted sample that turns the result from below to above
	sequence s_rise;
		sample_i && comp_active_o && decision_i && !result_o;
	endsequence
	// Pulses of a rise; a second sample changes them only one cycle later
	sequence s_up_pulse;
		up_o && cross_o && !down_o;
	endsequence
	sequence s_no_take;
		!(sample_i && comp_active_o);
	endsequence

	a_result_capture: assert property (sample_i && comp_active_o |=> result_o == $past(decision_i))
		else $error("result not taken at sample");
	a_result_held: assert property (!(sample_i && comp_active_o) |=> $stable(result_o))
		else $error("result moved without sample");
	a_rise_events: assert property (s_rise |=> s_up_pulse)
		else $error("rise of result gave wrong events");
	a_pulse_single: assert property (s_rise ##1 s_no_take |=> !up_o && !cross_o)
		else $error("event pulse longer than one cycle");
	a_enable_code: assert property (wr_i && addr_i == `CCR_OFF_ENABLE |=>
		comp_active_o == ($past(wdata_i[1:0]) == 2'h2))
		else $error("active does not follow enable code");
	a_ref_write: assert property (wr_i && addr_i == `CCR_OFF_REFSRC |=>
		reference_choice_o == $past(wdata_i[2:0]))
		else $error("reference code not stored");
	a_ext_option: assert property (external_ref_option_o ==
		(!diff_mode_o && reference_choice_o == 3'h5))
		else $error("external option wrong for mode and code");
	a_extref_write: assert property (wr_i && addr_i == `CCR_OFF_EXTREF |=>
		external_ref_input_choice_o == $past(wdata_i[2:0]))
		else $error("external input index not stored");
	a_thresh_write: assert property (wr_i && addr_i == `CCR_OFF_THRESH |=>
		lower_threshold_code_o == $past(wdata_i[5:0])
		&& upper_threshold_code_o == $past(wdata_i[13:8]))
		else $error("threshold codes not stored");
	a_mode_write: assert property (wr_i && addr_i == `CCR_OFF_OPCFG |=>
		speed_power_setting_o == $past(wdata_i[1:0]) && diff_mode_o == $past(wdata_i[8]))
		else $error("mode fields not stored");
	a_hyst_write: assert property (wr_i && addr_i == `CCR_OFF_HYSTCTL |=>
		hyst_en_o == $past(wdata_i[0]))
		else $error("hysteresis bit not stored");
	a_inten_set: assert property (wr_i && addr_i == `CCR_OFF_INT_SET |=>
		interrupt_enable_o == ($past(interrupt_enable_o) | $past(wdata_i[3:0])))
		else $error("set write did not merge into mask");
	a_read_result: assert property (rd_i && addr_i == `CCR_OFF_RESULT |=>
		rdata_o == {31'h0, $past(result_o)})
		else $error("result read wrong");
endmodule // ccr_checker

bind ccr_top ccr_checker ccr_checker_inst (.*);

// ### verification/testbench.sv
/*
 Self-checking bench of the comparator control block.
 Assumes ccr_top with the checker bound to it and a 20 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
	// Stimulus and observed ports
	logic        ref_clk_i  = 1'b0;
	logic        rst_b_i    = 1'b0;
	logic [11:0] addr_i     = 12'h000;
	logic [31:0] wdata_i    = 32'h0000_0000;
	logic        wr_i = 1'b0, rd_i = 1'b0, decision_i = 1'b0, sample_i = 1'b0;
	logic [31:0] rdata_o;
	logic [2:0]  reference_choice_o, external_ref_input_choice_o;
	logic [5:0]  lower_threshold_code_o, upper_threshold_code_o;
	logic [1:0]  speed_power_setting_o;
	logic [2:0]  input_pin_choice_o;
	logic [1:0]  input_bias_current_o;
	logic [3:0]  interrupt_enable_o;
	logic        comp_active_o, ref_valid_o, ref_applies_o, external_ref_option_o;
	logic        diff_mode_o, hyst_en_o, result_o, ready_o, up_o, down_o, cross_o;
	int          n_mismatch = 0;
	int          samples_checked = 0;

	ccr_top ccr_top_inst (.*);

	// 50 ns period
	always #25 ref_clk_i = ~ref_clk_i;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One-cycle write strobe; outputs settled on return
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(what, rdata_o, exp);
	endtask

	task automatic smp(input logic d);
		@(posedge ref_clk_i);
		decision_i <= d;
		sample_i   <= 1'b1;
		@(posedge ref_clk_i);
		sample_i <= 1'b0;
		#1;
	endtask

	task automatic t_reset;
		logic [11:0] ra [8] = '{12'h400, 12'h500, 12'h508, 12'h50c, 12'h530, 12'h534,
			12'h538, 12'h304};
		logic [31:0] rv [8] = '{0, 0, 4, 0, 0, 0, 0, 0};
		for (int i = 0; i < 8; i++)
			rd("reset value", ra[i], rv[i]);
		chk("active at reset", comp_active_o, 0);
		wr(12'h7fc, 32'hffff_ffff);
		rd("unmapped", 12'h7fc, 0);
	endtask

	task automatic t_enable;
		wr(12'h500, 32'h0000_0001);
		chk("active code 1", comp_active_o, 0);
		wr(12'h500, 32'h0000_0002);
		chk("active code 2", comp_active_o, 1);
		@(posedge ref_clk_i);
		#1;
		chk("ready pulse", ready_o, 1);
		wr(12'h500, 32'h0000_0000);
		chk("active off", comp_active_o, 0);
	endtask

	task automatic t_sample;
		wr(12'h500, 32'h0000_0002);
		smp(1'b1);
		chk("result above", {up_o, cross_o, down_o, result_o}, 4'hd);
		rd("result read", 12'h400, 1);
		wr(12'h500, 32'h0000_0000);
		smp(1'b0);
		chk("sample while off", result_o, 1);
		wr(12'h500, 32'h0000_0002);
		smp(1'b0);
		chk("result below", {up_o, cross_o, down_o, result_o}, 4'h6);
		@(posedge ref_clk_i);
		decision_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk("held between samples", result_o, 0);
	endtask

	task automatic t_ref;
		logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
		foreach (codes[i])
		begin
			wr(12'h508, {29'h0, codes[i]});
			chk("reference code", reference_choice_o, codes[i]);
			chk("external option", external_ref_option_o, codes[i] == 3'h5);
			chk("reference valid", ref_valid_o, 1);
			chk("reference applies", ref_applies_o, 1);
			rd("reference read", 12'h508, {29'h0, codes[i]});
		end
		wr(12'h508, 32'h0000_0003);
		chk("reserved reference", ref_valid_o, 0);
		wr(12'h508, 32'h0000_0005);
		wr(12'h534, 32'h0000_0100);
		chk("differential", {diff_mode_o, ref_applies_o, external_ref_option_o}, 3'h4);
		rd("mode read", 12'h534, 32'h0000_0100);
		for (int i = 0; i < 8; i++)
		begin
			wr(12'h50c, i);
			chk("external index", external_ref_input_choice_o, i);
			rd("external read", 12'h50c, i);
		end
	endtask

	task automatic t_levels;
		wr(12'h530, 32'hffff_ffff);
		chk("codes at 63", {upper_threshold_code_o, lower_threshold_code_o}, 12'hfff);
		rd("threshold read", 12'h530, 32'h0000_3f3f);
		wr(12'h530, 32'h0000_003f);
		chk("low 63 up 0", {upper_threshold_code_o, lower_threshold_code_o}, 12'h03f);
		for (int i = 0; i < 3; i++)
		begin
			wr(12'h534, i);
			chk("speed", speed_power_setting_o, i);
		end
		wr(12'h538, 32'h0000_0001);
		chk("hysteresis on", hyst_en_o, 1);
		rd("hysteresis read", 12'h538, 1);
		wr(12'h538, 32'h0000_0000);
		chk("hysteresis off", hyst_en_o, 0);
		// Pin and bias fields carry no rule but drive the core
		wr(12'h504, 32'h0000_0007);
		chk("pin choice", input_pin_choice_o, 7);
		wr(12'h53c, 32'h0000_0003);
		chk("bias current", input_bias_current_o, 3);
	endtask

	task automatic t_inten;
		wr(12'h304, 32'h0000_0001);
		wr(12'h304, 32'h0000_0004);
		wr(12'h304, 32'h0000_0000);
		rd("set merges", 12'h304, 5);
		chk("mask out", interrupt_enable_o, 5);
		wr(12'h308, 32'h0000_0001);
		rd("clear one", 12'h300, 4);
		wr(12'h300, 32'h0000_000a);
		rd("direct write", 12'h308, 32'h0000_000a);
		chk("mask direct", interrupt_enable_o, 4'ha);
	endtask

	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence after 12 cycles of reset
	initial
	begin
		repeat (12) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_enable();
		t_sample();
		t_ref();
		t_levels();
		t_inten();
		close_out();
	end

	// Whole run needs some 155 cycles
	initial
	begin
		repeat (3000) @(posedge ref_clk_i);
		n_mismatch++;
		close_out();
	end
endmodule // testbench
